// file: ckm_pkg.sv
// constants for clock-mode and hf oscillator control
// Overview of operation
// - low-power enable bit 2 allows low-power modes
// - peripheral clock enables act only under low-power
// - request enable bit 1 makes requests demand-driven
// - force-tree bit 0 gates only in idle
// - osc enable bit 7 turns oscillator on/off
// - ready flag bit 6 shows oscillator running
package ckm_pkg;
  localparam logic [7:0] ADDR_HF_OSC_CTL   = 8'h00_B2;
  localparam logic [7:0] ADDR_CLK_MODE_CTL = 8'h00_F7;
  localparam logic [3:0] SFR_PAGE_CLK      = 4'h0;

  localparam int LOW_POWER_ENABLE_BIT     = 2;
  localparam int CLOCK_REQUEST_ENABLE_BIT = 1;
  localparam int FORCE_CLOCK_TREE_BIT     = 0;
  localparam int HF_OSC_ENABLE_BIT        = 7;
  localparam int HF_OSC_READY_BIT         = 6;

  localparam logic [7:0] CLK_MODE_RESET   = 8'h00_00;
  localparam logic [5:0] OSC_RSVD_RESET   = 6'h00;
  localparam logic       HF_OSC_EN_RESET  = 1'b0;

  localparam int N_PERIPH = 8;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int OSC_SETTLE_NS  = 2000;
  localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W       = 8;
endpackage

// file: ckm_osc_if.sv
// enable and ready between register block and oscillator settle logic
`timescale 1ns/10ps
`default_nettype none
interface ckm_osc_if;
  logic enable;
  logic ready;
  modport regs (output enable, input ready);
  modport osc  (input enable, output ready);
endinterface
`default_nettype wire

// file: ckm_osc_settle.sv
// hf oscillator settle timer producing the ready flag
`timescale 1ns/10ps
`default_nettype none
module ckm_osc_settle (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  ckm_osc_if.osc    osc
);
  localparam logic [ckm_pkg::SETTLE_W-1:0] SETTLE_LAST =
    ckm_pkg::SETTLE_W'(ckm_pkg::OSC_SETTLE_CYC);

  logic [ckm_pkg::SETTLE_W-1:0] cnt_r;
  logic [ckm_pkg::SETTLE_W-1:0] cnt_nxt;
  logic                         ready_r;
  wire                          settled = (cnt_r == SETTLE_LAST);

  // restart from zero on every disable so a re-enable waits the full time
  assign cnt_nxt = !osc.enable ? '0 : (settled ? cnt_r : cnt_r + 1'b1);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r   <= '0;
      ready_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      ready_r <= osc.enable && settled;
    end
  end

  assign osc.ready = ready_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  a_ready_when_off: assert property (!osc.enable |=> !osc.ready)
    else $error("ready high after oscillator disabled");
  a_ready_settle_wait: assert property ($rose(osc.enable) |=> !osc.ready [*8])
    else $error("ready rose before settle time");
  a_ready_reaches: assert property ($rose(osc.enable) ##1 osc.enable [*8]
                                    |-> ##[1:200] (osc.ready || !osc.enable))
    else $error("ready never rose while enabled");
  c_ready_rise: cover property ($rose(osc.ready));
endmodule
`default_nettype wire

// file: ckm_top.sv
// clock-mode and hf oscillator control registers on the sfr bus
`timescale 1ns/10ps
`default_nettype none
module ckm_top (
  input  wire logic                         mclk_i,
  input  wire logic                         rst_b_i,
  input  wire logic [3:0]                   sfr_page_i,
  input  wire logic [7:0]                   sfr_addr_i,
  input  wire logic                         sfr_wr_i,
  input  wire logic                         sfr_rd_i,
  input  wire logic [7:0]                   sfr_wdata_i,
  output logic      [7:0]                   sfr_rdata_o,
  input  wire logic                         idle_mode_i,
  input  wire logic [ckm_pkg::N_PERIPH-1:0] peripheral_clock_enables_i,
  input  wire logic [ckm_pkg::N_PERIPH-1:0] periph_clk_request_i,
  output logic      [ckm_pkg::N_PERIPH-1:0] periph_clk_run_o,
  output logic                              src_clk_request_o,
  output logic                              low_power_mode_o,
  output logic                              hf_osc_enable_o,
  output logic                              hf_osc_ready_o
);
  localparam logic [ckm_pkg::N_PERIPH-1:0] ALL_RUN = '1;

  ckm_osc_if osc_if ();

  ckm_osc_settle u_settle (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .osc     (osc_if.osc)
  );

  logic                         low_power_enable_r;
  logic                         clock_request_enable_r;
  logic                         force_clock_tree_r;
  logic                         hf_osc_enable_r;
  logic [5:0]                   osc_rsvd_r;
  logic [7:0]                   rdata_r;
  logic [ckm_pkg::N_PERIPH-1:0] periph_run_r;
  logic                         src_req_r;

  // register decode
  wire page_hit   = (sfr_page_i == ckm_pkg::SFR_PAGE_CLK);
  wire sel_mode   = page_hit && (sfr_addr_i == ckm_pkg::ADDR_CLK_MODE_CTL);
  wire sel_osc    = page_hit && (sfr_addr_i == ckm_pkg::ADDR_HF_OSC_CTL);
  wire wr_mode    = sfr_wr_i && sel_mode;
  wire wr_osc     = sfr_wr_i && sel_osc;

  wire [7:0] mode_rd = {5'h00, low_power_enable_r, clock_request_enable_r,
                        force_clock_tree_r};
  wire [7:0] osc_rd  = {hf_osc_enable_r, osc_if.ready, osc_rsvd_r};
  // unmapped addresses read as zero
  wire [7:0] rd_mux  = sel_mode ? mode_rd : (sel_osc ? osc_rd : 8'h00);
  wire [7:0] rdata_nxt = sfr_rd_i ? rd_mux : rdata_r;

  // gating decision: without low-power all peripherals clock freely
  wire [ckm_pkg::N_PERIPH-1:0] demand = peripheral_clock_enables_i | periph_clk_request_i;
  wire tree_forced = force_clock_tree_r && !idle_mode_i;
  wire [ckm_pkg::N_PERIPH-1:0] periph_run_nxt =
    (!low_power_enable_r || tree_forced) ? ALL_RUN : demand;
  // request only on demand when enabled; otherwise always request
  wire src_req_nxt = !clock_request_enable_r ? 1'b1
                   : ((|periph_clk_request_i) || (|periph_run_nxt));

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_power_enable_r     <= ckm_pkg::CLK_MODE_RESET[ckm_pkg::LOW_POWER_ENABLE_BIT];
      clock_request_enable_r <= ckm_pkg::CLK_MODE_RESET[ckm_pkg::CLOCK_REQUEST_ENABLE_BIT];
      force_clock_tree_r     <= ckm_pkg::CLK_MODE_RESET[ckm_pkg::FORCE_CLOCK_TREE_BIT];
    end else if (wr_mode) begin
      low_power_enable_r     <= sfr_wdata_i[ckm_pkg::LOW_POWER_ENABLE_BIT];
      clock_request_enable_r <= sfr_wdata_i[ckm_pkg::CLOCK_REQUEST_ENABLE_BIT];
      force_clock_tree_r     <= sfr_wdata_i[ckm_pkg::FORCE_CLOCK_TREE_BIT];
    end
  end

  // whole-byte write; software keeps other bits by read-modify-write
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hf_osc_enable_r <= ckm_pkg::HF_OSC_EN_RESET;
      osc_rsvd_r      <= ckm_pkg::OSC_RSVD_RESET;
    end else if (wr_osc) begin
      hf_osc_enable_r <= sfr_wdata_i[ckm_pkg::HF_OSC_ENABLE_BIT];
      osc_rsvd_r      <= sfr_wdata_i[5:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r      <= 8'h00;
      periph_run_r <= ALL_RUN;
      src_req_r    <= 1'b1;
    end else begin
      rdata_r      <= rdata_nxt;
      periph_run_r <= periph_run_nxt;
      src_req_r    <= src_req_nxt;
    end
  end

  assign osc_if.enable     = hf_osc_enable_r;
  assign sfr_rdata_o       = rdata_r;
  assign periph_clk_run_o  = periph_run_r;
  assign src_clk_request_o = src_req_r;
  assign low_power_mode_o  = low_power_enable_r;
  assign hf_osc_enable_o   = hf_osc_enable_r;
  assign hf_osc_ready_o    = osc_if.ready;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  a_lp_bit_write: assert property (wr_mode |=>
      low_power_mode_o == $past(sfr_wdata_i[ckm_pkg::LOW_POWER_ENABLE_BIT]))
    else $error("low-power enable not taken from write");
  a_no_lp_gating: assert property (!low_power_mode_o |=> periph_clk_run_o == ALL_RUN)
    else $error("peripheral gated without low-power enable");
  a_lp_demand_gate: assert property (low_power_mode_o && !(force_clock_tree_r && !idle_mode_i)
      |=> periph_clk_run_o == $past(demand))
    else $error("peripheral gating not from enables");
  a_req_on_demand: assert property (clock_request_enable_r && periph_clk_request_i == '0
      && !tree_forced && low_power_mode_o && peripheral_clock_enables_i == '0
      |=> !src_clk_request_o)
    else $error("source clock requested without demand");
  a_req_free_run: assert property (!clock_request_enable_r |=> src_clk_request_o)
    else $error("source request dropped while not demand-driven");
  a_force_tree_active: assert property (low_power_mode_o && force_clock_tree_r
      && !idle_mode_i |=> periph_clk_run_o == ALL_RUN)
    else $error("clock tree gated in active mode");
  a_osc_en_write: assert property (wr_osc |=>
      hf_osc_enable_o == $past(sfr_wdata_i[ckm_pkg::HF_OSC_ENABLE_BIT]))
    else $error("oscillator enable not taken from write");
  a_ready_readback: assert property (sfr_rd_i && sel_osc |=>
      sfr_rdata_o[ckm_pkg::HF_OSC_READY_BIT] == $past(hf_osc_ready_o))
    else $error("ready flag readback mismatch");
  a_ready_needs_en: assert property (hf_osc_ready_o |-> $past(hf_osc_enable_o))
    else $error("ready without prior enable");

  c_lp_gating: cover property (low_power_mode_o ##1 periph_clk_run_o != ALL_RUN);
  c_req_drop: cover property (clock_request_enable_r ##1 !src_clk_request_o);
  c_force_idle: cover property (force_clock_tree_r && low_power_mode_o && idle_mode_i);
endmodule
`default_nettype wire

// file: ckm_testbench.sv
// self-checking testbench for clock-mode and hf oscillator control
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int WR = 0;
  localparam int RD = 1;
  localparam int LK = 2;
  logic        mclk_i  = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [3:0]  page_r  = 4'h0;
  logic [7:0]  addr_r  = 8'h00;
  logic [7:0]  wdata_r = 8'h00;
  logic        wr_r    = 1'b0;
  logic        rd_r    = 1'b0;
  logic        look_r  = 1'b0;
  logic        rd_d    = 1'b0;
  logic        look_d  = 1'b0;
  logic        idle_r  = 1'b0;
  logic [7:0]  pce_r   = 8'h00;
  logic [7:0]  req_r   = 8'h00;
  logic [7:0]  rdata, run, got, e_run, keep, pv, qv;
  logic        src, lpm, en, rdy;
  logic [10:0] expq[$];
  logic [10:0] note;
  logic [31:0] seed = 32'h7427_8711;
  logic [31:0] r;
  int          miscompares = 0;
  int          n_compared  = 0;
  int          cycles      = 0;

  ckm_top u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .sfr_page_i(page_r), .sfr_addr_i(addr_r),
    .sfr_wr_i(wr_r), .sfr_rd_i(rd_r), .sfr_wdata_i(wdata_r), .sfr_rdata_o(rdata),
    .idle_mode_i(idle_r), .peripheral_clock_enables_i(pce_r), .periph_clk_request_i(req_r),
    .periph_clk_run_o(run), .src_clk_request_o(src), .low_power_mode_o(lpm),
    .hf_osc_enable_o(en), .hf_osc_ready_o(rdy));

  initial begin
    forever #10 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic print_verdict();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // k: write, read (d = expected) or look (a = output select, d = expected)
  // strobes drop one edge before the next op, so nothing is assigned twice
  task automatic op(input int k, input logic [3:0] p, input logic [7:0] a, d);
    @(posedge mclk_i);
    page_r  <= p;
    addr_r  <= a;
    wdata_r <= d;
    wr_r    <= (k == WR);
    rd_r    <= (k == RD);
    look_r  <= (k == LK);
    if (k == RD) expq.push_back({3'd0, d});
    if (k == LK) expq.push_back({a[2:0], d});
    @(posedge mclk_i);
    wr_r    <= 1'b0;
    rd_r    <= 1'b0;
    look_r  <= 1'b0;
  endtask

  always @(posedge mclk_i) begin
    rd_d   <= rd_r;
    look_d <= look_r;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  // results sampled mid-cycle, after the edge that produced them
  always @(negedge mclk_i) begin
    if (rd_d || look_d) begin
      note = expq.pop_front();
      case (note[10:8])
        3'd1:    got = run;
        3'd2:    got = {7'h00, src};
        3'd3:    got = {7'h00, lpm};
        3'd4:    got = {7'h00, en};
        3'd5:    got = {7'h00, rdy};
        default: got = rdata;
      endcase
      n_compared++;
      if (got !== note[7:0]) begin
        miscompares++;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, note[7:0]);
      end
    end
  end

  initial begin
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    op(LK, 4'h0, 8'h01, 8'hFF);
    op(LK, 4'h0, 8'h02, 8'h01);
    op(LK, 4'h0, 8'h03, 8'h00);
    op(LK, 4'h0, 8'h04, 8'h00);
    op(LK, 4'h0, 8'h05, 8'h00);
    op(RD, 4'h0, ckm_pkg::ADDR_CLK_MODE_CTL, ckm_pkg::CLK_MODE_RESET);
    op(RD, 4'h0, ckm_pkg::ADDR_HF_OSC_CTL, 8'h00);
    for (int i = 0; i < 16; i++) begin
      r = xs();
      // zero enables and requests where demand-driven requests may drop
      pv = (i[2:1] == 2'b11) ? 8'h00 : r[7:0];
      qv = (i[2:1] == 2'b11) ? 8'h00 : r[15:8];
      e_run = (!i[2] || (i[0] && !i[3])) ? 8'hFF : (pv | qv);
      @(posedge mclk_i);
      idle_r <= i[3];
      pce_r  <= pv;
      req_r  <= qv;
      op(WR, 4'h0, ckm_pkg::ADDR_CLK_MODE_CTL, {r[20:16], i[2:0]});
      op(RD, 4'h0, ckm_pkg::ADDR_CLK_MODE_CTL, {5'h00, i[2:0]});
      op(LK, 4'h0, 8'h03, {7'h00, i[2]});
      op(LK, 4'h0, 8'h01, e_run);
      op(LK, 4'h0, 8'h02, {7'h00, !i[1] || (|(qv | e_run))});
    end
    op(WR, 4'h1, ckm_pkg::ADDR_CLK_MODE_CTL, 8'h00);
    op(RD, 4'h0, ckm_pkg::ADDR_CLK_MODE_CTL, 8'h07);
    op(RD, 4'h1, ckm_pkg::ADDR_CLK_MODE_CTL, 8'h00);
    op(RD, 4'h0, 8'h55, 8'h00);
    r = xs();
    keep = {2'b11, r[5:0]};
    op(WR, 4'h0, ckm_pkg::ADDR_HF_OSC_CTL, keep);
    op(LK, 4'h0, 8'h04, 8'h01);
    op(RD, 4'h0, ckm_pkg::ADDR_HF_OSC_CTL, {2'b10, r[5:0]});
    repeat (110) @(posedge mclk_i);
    op(LK, 4'h0, 8'h05, 8'h01);
    op(RD, 4'h0, ckm_pkg::ADDR_HF_OSC_CTL, keep);
    op(WR, 4'h0, ckm_pkg::ADDR_HF_OSC_CTL, keep & 8'h7F);
    op(LK, 4'h0, 8'h05, 8'h00);
    op(RD, 4'h0, ckm_pkg::ADDR_HF_OSC_CTL, {2'b00, r[5:0]});
    // let the last noted result reach the checker before the verdict
    repeat (2) @(posedge mclk_i);
    if (expq.size() != 0) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, expq.size(), 0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
